// ===== rtl/mcsr_consts.svh
// register offsets, field positions, reset values and encodings
`ifndef MCSR_CONSTS_SVH
`define MCSR_CONSTS_SVH

// ----------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------
`define MCSR_OFS_ACC     8'h00
`define MCSR_OFS_PCL     8'h04
`define MCSR_OFS_TBLPTR  8'h08
`define MCSR_OFS_TBLHI   8'h0c
`define MCSR_OFS_STATUS  8'h10
`define MCSR_OFS_INTA    8'h14
`define MCSR_OFS_INTB    8'h18
`define MCSR_OFS_RTC_INTERVAL_CONTROL    8'h1c
`define MCSR_OFS_DISP    8'h20
`define MCSR_OFS_TACNT   8'h24
`define MCSR_OFS_TACTL   8'h28
`define MCSR_OFS_TBHI    8'h2c
`define MCSR_OFS_TBLO    8'h30
`define MCSR_OFS_TBCTL   8'h34
`define MCSR_OFS_PA      8'h38
`define MCSR_OFS_PB      8'h3c
`define MCSR_OFS_PC      8'h40
`define MCSR_OFS_PCC     8'h44
`define MCSR_OFS_PD      8'h48

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MCSR_ST_PDF      4
`define MCSR_ST_TO       5
`define MCSR_RTC_INTERVAL_CONTROL_OSC_QUICK_START   4
`define MCSR_DISP_DISPLAY_DRIVER_ENABLE  4
`define MCSR_DISP_RTC_ENABLE  5
`define MCSR_TCTL_ON     4
`define MCSR_TCTL_EXT    5
`define MCSR_INTA_GIE    0
`define MCSR_RTC_BASE    8

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define MCSR_RST_ZERO    8'h00
`define MCSR_RST_PORT    8'hff
`define MCSR_FS_RTC      2'h2
`define MCSR_RESP_OKAY   2'b00
`define MCSR_RESP_DECERR 2'b11

`endif

// ===== rtl/mcsr_pkg.sv
// types and the alu function shared by the special register block
package mcsr_pkg;

  typedef enum logic [2:0] {
    ALU_LD, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_RLC, ALU_RRC
  } mcsr_alu_op_e;

  typedef struct packed {
    logic         valid;
    mcsr_alu_op_e op;
    logic [7:0]   operand;
  } mcsr_alu_req_s;

  typedef struct packed {
    logic        halt;
    logic        watchdog_clear_instruction;
    logic        wdt_timeout;
    logic        int_entry;
    logic        return_from_interrupt;
    logic        tbl_read;
    logic [14:0] prog_word;
    logic [7:0]  pc_low;
  } mcsr_core_evt_s;

  typedef struct packed {
    logic [1:0] fs_src;
    logic       wdt_en;
    logic       fs_tick;
    logic [7:0] pa;
    logic [7:0] pb;
    logic       pc;
    logic [3:0] pd;
  } mcsr_pins_s;

  // upd bit order follows status: 0 carry, 1 aux, 2 zero, 3 overflow
  typedef struct packed {
    logic [7:0] result;
    logic [3:0] upd;
    logic       ov;
    logic       z;
    logic       ac;
    logic       c;
  } mcsr_alu_res_s;

  // subtraction runs as a + ~b + 1 so carry means no borrow
  function automatic mcsr_alu_res_s mcsr_alu(
    input mcsr_alu_op_e op,
    input logic [7:0]   a,
    input logic [7:0]   b,
    input logic         c_in
  );
    logic [7:0]    bb;
    logic          cin;
    logic [8:0]    full;
    logic [4:0]    low;
    logic [7:0]    hi7;
    mcsr_alu_res_s r;
    bb = (op == ALU_SUB) ? ~b : b;
    cin = (op == ALU_SUB);
    full = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
    hi7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, cin};
    r.result = full[7:0];
    r.c = full[8];
    r.ac = low[4];
    r.ov = hi7[7] ^ full[8];
    r.upd = 4'hf;
    case (op)
      ALU_ADD, ALU_SUB: r.upd = 4'hf;
      ALU_AND:
      begin
        r.result = a & b;
        r.upd = 4'h4;
      end
      ALU_OR:
      begin
        r.result = a | b;
        r.upd = 4'h4;
      end
      ALU_XOR:
      begin
        r.result = a ^ b;
        r.upd = 4'h4;
      end
      ALU_RLC:
      begin
        r.result = {a[6:0], c_in};
        r.c = a[7];
        r.upd = 4'h1;
      end
      ALU_RRC:
      begin
        r.result = {c_in, a[7:1]};
        r.c = a[0];
        r.upd = 4'h1;
      end
      default:
      begin
        r.result = b;
        r.upd = 4'h0;
      end
    endcase
    r.z = (r.result == 8'h00);
    return r;
  endfunction : mcsr_alu

endpackage : mcsr_pkg

// ===== rtl/mcsr_top.sv
// special function register bank of the small core, on an axi4-lite slave
// Operation
// R1 - alu results always land in accumulator
// R2 - pcl write jumps in page, dummy cycle
// R3 - table read stores high byte
// R4 - status writes never touch pdf, to
// R5 - carry: add carry out, sub no borrow
// R6 - aux carry from low nibble likewise
// R7 - zero flag marks a zero result
// R8 - overflow is carry into msb xor out
// R9 - pdf set by halt, cleared by clr
// R10 - to set by timeout, cleared clr/halt
// R11 - status is never stacked automatically
// R12 - rtc event every 2^8..2^15 fs ticks
// R13 - quick start bit clears at power-on
// R14 - software sets quick start after 2s
// R15 - gie gates interrupts, entry clears, return_from_interrupt sets
// R16 - lcd enable powers the whole driver
// R17 - segment select picks segment or port d
// R18 - rtc off for non-rtc fs sources
// R19 - rtc osc: on with wdt, lcd or enable
// R20 - timer a: preloadable 8-bit up counter
// R21 - timer b: preloadable 16-bit up counter
// R22 - port b input only, others bidirectional
// R23 - pcc one is input, zero cmos output
// R24 - flags update with the result cycle
`include "mcsr_consts.svh"

module mcsr_top (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             awaddr,
  input  wire logic                    wvalid,
  output logic                         wready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  output logic                         bvalid,
  input  wire logic                    bready,
  output logic [1:0]                   bresp,
  input  wire logic                    arvalid,
  output logic                         arready,
  input  wire logic [31:0]             araddr,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  input  wire mcsr_pkg::mcsr_alu_req_s  alu_req,
  input  wire mcsr_pkg::mcsr_core_evt_s core_evt,
  input  wire mcsr_pkg::mcsr_pins_s     pins_in,
  output logic [7:0]                   accumulator_reg,
  output logic [7:0]                   status,
  output logic                         pc_jump,
  output logic [7:0]                   pc_jump_low,
  output logic                         dummy_cycle,
  output logic [7:0]                   table_pointer,
  output logic                         irq_req,
  output logic                         osc_quick_start,
  output logic                         lcd_on,
  output logic                         rtc_on,
  output logic [3:0]                   seg_mode,
  output logic [7:0]                   pa_out,
  output logic [7:0]                   pa_oe,
  output logic                         pc_out,
  output logic                         pc_oe,
  output logic [3:0]                   pd_out,
  output logic [3:0]                   pd_oe
);
  import mcsr_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic          aw_take, next_aw_take, ar_take, next_ar_take;
  logic          next_bvalid, next_rvalid;
  logic [1:0]    next_bresp, next_rresp;
  logic [31:0]   next_rdata;
  mcsr_pins_s    pin_s1, pin_s2;
  logic [2:0]    edge_s3;
  logic [7:0]    table_high_byte, rtc_interval_control, display_control;
  logic [7:0]    interrupt_control_a, interrupt_control_b;
  logic [7:0]    timer_a_count, timer_a_control, timer_b_control;
  logic [15:0]   timer_b_count;
  logic [7:0]    pa_latch, pc_latch, port_c_direction;
  logic [3:0]    pd_latch;
  logic [14:0]   rtc_cnt;
  logic [7:0]    next_acc, next_status, next_table_pointer, next_table_high_byte, next_rtc_interval_control;
  logic [7:0]    next_disp, next_inta, next_intb, next_ta, next_tactl;
  logic [7:0]    next_tbctl, next_pa, next_pc, next_pcc, next_pcl_low;
  logic [15:0]   next_tb;
  logic [3:0]    next_pd;
  logic [14:0]   next_rtc_cnt;
  logic          next_jump, next_rtc_on, next_irq;
  logic          wr_fire, rd_fire, wr_en, ta_tick, tb_tick, rtc_evt;
  logic          fs_rise, pb2_rise, pb3_rise;
  logic [7:0]    w, rd_val;
  logic [14:0]   rtc_mask;
  mcsr_alu_res_s alu_res;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // aligned word inside the implemented window
  function automatic logic addr_hit(input logic [31:0] a);
    return (a[31:8] == 24'h000000) && (a[1:0] == 2'b00) &&
           (a[7:0] <= `MCSR_OFS_PD);
  endfunction : addr_hit

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // two stages before anything reads a pin, a third for edges only
  always_ff @(posedge aclk)
  begin
    pin_s1 <= pins_in;
    pin_s2 <= pin_s1;
    edge_s3 <= {pin_s2.fs_tick, pin_s2.pb[3], pin_s2.pb[2]};
  end
  assign fs_rise = pin_s2.fs_tick & ~edge_s3[2];
  assign pb3_rise = pin_s2.pb[3] & ~edge_s3[1];
  assign pb2_rise = pin_s2.pb[2] & ~edge_s3[0];

  // ----------------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------------
  // address and data are taken together, so neither can be half-consumed
  assign wr_fire = aw_take & awvalid & wvalid;
  assign rd_fire = ar_take & arvalid;
  assign wr_en = wr_fire & addr_hit(awaddr) & wstrb[0];
  assign w = wdata[7:0];
  assign awready = aw_take;
  assign wready = aw_take;
  assign arready = ar_take;

  always_comb
  begin
    next_aw_take = ~aw_take & awvalid & wvalid & ~bvalid;
    next_ar_take = ~ar_take & arvalid & ~rvalid;
    next_bvalid = wr_fire | (bvalid & ~bready);
    next_bresp = bresp;
    if (wr_fire)
      next_bresp = addr_hit(awaddr) ? `MCSR_RESP_OKAY : `MCSR_RESP_DECERR;
    next_rvalid = rd_fire | (rvalid & ~rready);
    next_rresp = rresp;
    next_rdata = rdata;
    if (rd_fire)
    begin
      next_rresp = addr_hit(araddr) ? `MCSR_RESP_OKAY : `MCSR_RESP_DECERR;
      next_rdata = {24'h000000, addr_hit(araddr) ? rd_val : 8'h00};
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_val = 8'h00;
    case (araddr[7:0])
      `MCSR_OFS_ACC:    rd_val = accumulator_reg;
      `MCSR_OFS_PCL:    rd_val = core_evt.pc_low;
      `MCSR_OFS_TBLPTR: rd_val = table_pointer;
      `MCSR_OFS_TBLHI:  rd_val = table_high_byte;
      `MCSR_OFS_STATUS: rd_val = status;
      `MCSR_OFS_INTA:   rd_val = interrupt_control_a;
      `MCSR_OFS_INTB:   rd_val = interrupt_control_b;
      `MCSR_OFS_RTC_INTERVAL_CONTROL:   rd_val = rtc_interval_control;
      `MCSR_OFS_DISP:   rd_val = display_control;
      `MCSR_OFS_TACNT:  rd_val = timer_a_count;
      `MCSR_OFS_TACTL:  rd_val = timer_a_control;
      `MCSR_OFS_TBHI:   rd_val = timer_b_count[15:8];
      `MCSR_OFS_TBLO:   rd_val = timer_b_count[7:0];
      `MCSR_OFS_TBCTL:  rd_val = timer_b_control;
      `MCSR_OFS_PA:     rd_val = pin_s2.pa;
      `MCSR_OFS_PB:     rd_val = pin_s2.pb;
      // R23 input reads the pin, output reads the latch
      `MCSR_OFS_PC:     rd_val = {7'h00, port_c_direction[0] ?
                                  pin_s2.pc : pc_latch[0]};
      `MCSR_OFS_PCC:    rd_val = port_c_direction;
      `MCSR_OFS_PD:     rd_val = {4'h0, pin_s2.pd};
      default:          rd_val = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // register file next values
  // ----------------------------------------------------------------------
  assign alu_res = mcsr_alu(alu_req.op, accumulator_reg, alu_req.operand,
                            status[0]);
  // R12 period mask widens with the divider select
  assign rtc_mask = 15'h7fff >> (3'd7 - rtc_interval_control[2:0]);
  assign rtc_evt = fs_rise & rtc_on & ((rtc_cnt & rtc_mask) == rtc_mask);
  // R20 timer a counts aclk or the synchronised external edge
  assign ta_tick = timer_a_control[`MCSR_TCTL_ON] &
                   (timer_a_control[`MCSR_TCTL_EXT] ? pb2_rise : 1'b1);
  // R21 timer b counts the same way on its own pin
  assign tb_tick = timer_b_control[`MCSR_TCTL_ON] &
                   (timer_b_control[`MCSR_TCTL_EXT] ? pb3_rise : 1'b1);

  always_comb
  begin
    next_acc = accumulator_reg;
    next_status = status;
    next_table_pointer = table_pointer;
    next_table_high_byte = table_high_byte;
    next_rtc_interval_control = rtc_interval_control;
    next_disp = display_control;
    next_inta = interrupt_control_a;
    next_intb = interrupt_control_b;
    next_ta = timer_a_count + {7'h00, ta_tick};
    next_tactl = timer_a_control;
    next_tb = timer_b_count + {15'h0000, tb_tick};
    next_tbctl = timer_b_control;
    next_pa = pa_latch;
    next_pc = pc_latch;
    next_pcc = port_c_direction;
    next_pd = pd_latch;
    next_jump = 1'b0;
    next_pcl_low = pc_jump_low;
    if (wr_en)
    begin
      case (awaddr[7:0])
        `MCSR_OFS_ACC:    next_acc = w;
        // R2 an 8-bit target only reaches the current page
        `MCSR_OFS_PCL:
        begin
          next_jump = 1'b1;
          next_pcl_low = w;
        end
        `MCSR_OFS_TBLPTR: next_table_pointer = w;
        // R4 only the arithmetic flags take bus data
        `MCSR_OFS_STATUS: next_status[3:0] = w[3:0];
        `MCSR_OFS_INTA:   next_inta = w;
        // request bits: writing zero clears, writing one keeps
        `MCSR_OFS_INTB:   next_intb = interrupt_control_b & w;
        `MCSR_OFS_RTC_INTERVAL_CONTROL:   next_rtc_interval_control = {3'b000, w[4], 1'b0, w[2:0]};
        `MCSR_OFS_DISP:   next_disp = {2'b00, w[5:0]};
        `MCSR_OFS_TACNT:  next_ta = w;
        `MCSR_OFS_TACTL:  next_tactl = w;
        `MCSR_OFS_TBHI:   next_tb[15:8] = w;
        `MCSR_OFS_TBLO:   next_tb[7:0] = w;
        `MCSR_OFS_TBCTL:  next_tbctl = w;
        `MCSR_OFS_PA:     next_pa = w;
        `MCSR_OFS_PC:     next_pc = w;
        `MCSR_OFS_PCC:    next_pcc = w;
        `MCSR_OFS_PD:     next_pd = w[3:0];
        default:          next_acc = accumulator_reg;
      endcase
    end
    // R1 the core result wins over a bus write in the same cycle
    if (alu_req.valid)
    begin
      next_acc = alu_res.result;
      // R24 flags load in the cycle the result does
      // R5 R6 R7 R8 per-op flag masks from the alu
      for (int i = 0; i < 4; i++)
        if (alu_res.upd[i])
          next_status[i] = alu_res[i];
    end
    // R9 halt sets, clear instruction clears
    if (core_evt.halt)
      next_status[`MCSR_ST_PDF] = 1'b1;
    else if (core_evt.watchdog_clear_instruction)
      next_status[`MCSR_ST_PDF] = 1'b0;
    // R10 a time-out wins over a clear in the same cycle
    if (core_evt.wdt_timeout)
      next_status[`MCSR_ST_TO] = 1'b1;
    else if (core_evt.watchdog_clear_instruction | core_evt.halt)
      next_status[`MCSR_ST_TO] = 1'b0;
    // R11 no stacking here: the core must save status in software
    // R3 the word's upper bits become the table high byte
    if (core_evt.tbl_read)
      next_table_high_byte = {1'b0, core_evt.prog_word[14:8]};
    // R15 return sets the master enable, entry clears it
    if (core_evt.return_from_interrupt)
      next_inta[`MCSR_INTA_GIE] = 1'b1;
    else if (core_evt.int_entry)
      next_inta[`MCSR_INTA_GIE] = 1'b0;
    // sticky requests: a set beats a clear in the same cycle
    next_intb[0] = next_intb[0] | rtc_evt;
    next_intb[1] = next_intb[1] | (ta_tick & (timer_a_count == 8'hff));
    next_intb[2] = next_intb[2] | (tb_tick & (timer_b_count == 16'hffff));
  end

  // ----------------------------------------------------------------------
  // rtc, display and interrupt gating next values
  // ----------------------------------------------------------------------
  always_comb
  begin
    // R18 R19 rtc runs only from the rtc oscillator
    next_rtc_on = (pin_s2.fs_src == `MCSR_FS_RTC) &
                  (pin_s2.wdt_en | display_control[`MCSR_DISP_DISPLAY_DRIVER_ENABLE] |
                   display_control[`MCSR_DISP_RTC_ENABLE]);
    // R12 free divider of fs ticks, held in reset while off
    next_rtc_cnt = rtc_on ? rtc_cnt + {14'h0000, fs_rise} : 15'h0000;
    // R15 the master enable gates every source
    next_irq = interrupt_control_a[`MCSR_INTA_GIE] &
               (|(interrupt_control_a[3:1] & interrupt_control_b[2:0]));
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_take <= 1'b0;
      ar_take <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `MCSR_RESP_OKAY;
      rvalid <= 1'b0;
      rresp <= `MCSR_RESP_OKAY;
      rdata <= 32'h00000000;
      accumulator_reg <= `MCSR_RST_ZERO;
      // R9 R10 power-up clears both system flags
      status <= `MCSR_RST_ZERO;
      table_pointer <= `MCSR_RST_ZERO;
      table_high_byte <= `MCSR_RST_ZERO;
      // R13 quick start bit clear after power-on
      rtc_interval_control <= `MCSR_RST_ZERO;
      display_control <= `MCSR_RST_ZERO;
      interrupt_control_a <= `MCSR_RST_ZERO;
      interrupt_control_b <= `MCSR_RST_ZERO;
      timer_a_count <= `MCSR_RST_ZERO;
      timer_a_control <= `MCSR_RST_ZERO;
      timer_b_count <= 16'h0000;
      timer_b_control <= `MCSR_RST_ZERO;
      pa_latch <= `MCSR_RST_PORT;
      pc_latch <= `MCSR_RST_PORT;
      port_c_direction <= `MCSR_RST_PORT;
      pd_latch <= 4'hf;
      pc_jump <= 1'b0;
      pc_jump_low <= `MCSR_RST_ZERO;
      dummy_cycle <= 1'b0;
      rtc_cnt <= 15'h0000;
      rtc_on <= 1'b0;
      irq_req <= 1'b0;
      lcd_on <= 1'b0;
      osc_quick_start <= 1'b0;
      seg_mode <= 4'h0;
      pa_out <= `MCSR_RST_ZERO;
      pa_oe <= `MCSR_RST_ZERO;
      pc_out <= 1'b1;
      pc_oe <= 1'b0;
      pd_out <= 4'h0;
      pd_oe <= 4'h0;
    end
    else
    begin
      aw_take <= next_aw_take;
      ar_take <= next_ar_take;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      accumulator_reg <= next_acc;
      status <= next_status;
      table_pointer <= next_table_pointer;
      table_high_byte <= next_table_high_byte;
      rtc_interval_control <= next_rtc_interval_control;
      display_control <= next_disp;
      interrupt_control_a <= next_inta;
      interrupt_control_b <= next_intb;
      timer_a_count <= next_ta;
      timer_a_control <= next_tactl;
      timer_b_count <= next_tb;
      timer_b_control <= next_tbctl;
      pa_latch <= next_pa;
      pc_latch <= next_pc;
      port_c_direction <= next_pcc;
      pd_latch <= next_pd;
      pc_jump <= next_jump;
      pc_jump_low <= next_pcl_low;
      // R2 one dummy cycle follows each pcl jump
      dummy_cycle <= pc_jump;
      rtc_cnt <= next_rtc_cnt;
      rtc_on <= next_rtc_on;
      irq_req <= next_irq;
      // R16 driver power follows its enable alone
      lcd_on <= display_control[`MCSR_DISP_DISPLAY_DRIVER_ENABLE];
      osc_quick_start <= rtc_interval_control[`MCSR_RTC_INTERVAL_CONTROL_OSC_QUICK_START];
      // R17 a set select hands the pin to the segment driver
      seg_mode <= display_control[3:0];
      // R22 a and d are open drain, b has no driver at all
      pa_out <= `MCSR_RST_ZERO;
      pa_oe <= ~pa_latch;
      // R23 direction one releases the pin, zero drives cmos
      pc_out <= pc_latch[0];
      pc_oe <= ~port_c_direction[0];
      pd_out <= 4'h0;
      pd_oe <= ~pd_latch & ~display_control[3:0];
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_pcl_write;
    wr_en && (awaddr[7:0] == `MCSR_OFS_PCL);
  endsequence
  sequence s_jump_then_dummy;
    pc_jump ##1 dummy_cycle ##1 !dummy_cycle;
  endsequence

  chk_pcl_jump: assert property (  // R2
    s_pcl_write |=> s_jump_then_dummy) else $error("pcl jump sequence");
  chk_acc_result: assert property (  // R1
    alu_req.valid |=> accumulator_reg == $past(alu_res.result))
    else $error("alu result missed");
  chk_zero_flag: assert property (  // R7
    alu_req.valid && alu_res.upd[2] |=> status[2] == (accumulator_reg == 0))
    else $error("zero flag wrong");
  chk_status_protect: assert property (  // R4
    wr_en && awaddr[7:0] == `MCSR_OFS_STATUS && !core_evt.halt &&
    !core_evt.watchdog_clear_instruction && !core_evt.wdt_timeout
    |=> $stable(status[5:4])) else $error("status write hit pdf or to");
  chk_pdf_halt: assert property (  // R9
    core_evt.halt |=> status[`MCSR_ST_PDF]) else $error("halt pdf");
  chk_to_clear: assert property (  // R10
    core_evt.watchdog_clear_instruction && !core_evt.wdt_timeout |=> !status[`MCSR_ST_TO])
    else $error("to not cleared");
  chk_tbl_high: assert property (  // R3
    core_evt.tbl_read |=> table_high_byte[6:0] ==
    $past(core_evt.prog_word[14:8])) else $error("table high byte");
  chk_gie_entry: assert property (  // R15
    core_evt.int_entry && !core_evt.return_from_interrupt ##1 !core_evt.return_from_interrupt && !wr_en
    |=> !irq_req) else $error("irq after entry");
  chk_rtc_source: assert property (  // R18
    pin_s2.fs_src != `MCSR_FS_RTC |=> !rtc_on) else $error("rtc ran");
  chk_lcd_follow: assert property (  // R16
    wr_en && awaddr[7:0] == `MCSR_OFS_DISP
    |=> ##1 lcd_on == $past(w[4], 2)) else $error("lcd enable lag");
  chk_pc_dir: assert property (  // R23
    port_c_direction[0] |=> !pc_oe) else $error("pc driven as input");

endmodule : mcsr_top

// ===== dv/mcsr_top_tb_top.sv
// self-checking bench for the special register bank
module mcsr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import mcsr_pkg::*;
  logic aclk = 0, aresetn = 0;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, seg, pd_out, pd_oe, h;
  logic [1:0] bresp, rresp;
  mcsr_alu_req_s alu_req;
  mcsr_core_evt_s core_evt;
  mcsr_pins_s pins_in;
  logic [7:0] acc, st, pjl, tp, pa_out, pa_oe;
  logic pj, dc, irq, qs, lcd, rtc, pc_out, pc_oe;
  int failures = 0, n_checks = 0;
  assign h = {rvalid, arready, bvalid, awready};
  // 250 MHz core clock
  always #2 aclk = ~aclk;
  mcsr_top u_mcsr_top (.aclk, .aresetn, .awvalid, .awready, .awaddr,
    .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid,
    .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .alu_req,
    .core_evt, .pins_in, .accumulator_reg(acc), .status(st),
    .pc_jump(pj), .pc_jump_low(pjl), .dummy_cycle(dc),
    .table_pointer(tp), .irq_req(irq), .osc_quick_start(qs),
    .lcd_on(lcd), .rtc_on(rtc), .seg_mode(seg), .pa_out, .pa_oe,
    .pc_out, .pc_oe, .pd_out, .pd_oe);
  task automatic summarize();
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string n, input logic [7:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // bounded wait for one handshake flag sampled at an edge
  task automatic hs(input int s);
    int k;
    k = 0;
    do @(posedge aclk); while (h[s] !== 1'b1 && ++k < 64);
    if (k >= 64)
    begin
      failures++;
      summarize();
    end
  endtask : hs
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'b00);
    awaddr <= {24'h0, a};
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= 3'b111;
    hs(0);
    {awvalid, wvalid} <= 2'b00;
    hs(1);
    bready <= 1'b0;
    chk("bresp", {6'h0, r}, {6'h0, bresp});
    // an edge passes so a following call never re-drives ready this step
    @(posedge aclk);
  endtask : wr
  task automatic rc(input logic [7:0] a, e, input logic [1:0] r = 2'b00);
    araddr <= {24'h0, a};
    {arvalid, rready} <= 2'b11;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    rready <= 1'b0;
    chk("rdata", e, rdata[7:0]);
    chk("rresp", {6'h0, r}, {6'h0, rresp});
    @(posedge aclk);
  endtask : rc
  task automatic op(input mcsr_alu_op_e o, input logic [7:0] b);
    alu_req <= {1'b1, o, b};
    @(posedge aclk);
    alu_req <= '0;
    @(posedge aclk);
  endtask : op
  // one-cycle core event pulse on a bit of the event struct
  task automatic ev(input int b);
    core_evt[b] <= 1'b1;
    @(posedge aclk);
    core_evt[b] <= 1'b0;
    @(posedge aclk);
  endtask : ev
  // one fs period, long enough for the pin synchroniser to see the rise
  task automatic tick();
    pins_in.fs_tick <= 1'b1;
    repeat (2) @(posedge aclk);
    pins_in.fs_tick <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : tick
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    alu_req = '0;
    core_evt = '0;
    pins_in = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(8'h10, 8'h00);
    rc(8'h1c, 8'h00);
    wr(8'h00, 8'h88);
    op(ALU_ADD, 8'h88);
    chk("acc", 8'h10, acc);
    chk("flags", 8'h0b, st);
    op(ALU_SUB, 8'h10);
    chk("flags", 8'h07, st);
    ev(28);
    ev(26);
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h30);
    ev(27);
    chk("status", 8'h00, st);
    ev(26);
    ev(28);
    chk("status", 8'h10, st);
    core_evt.prog_word <= 15'h5a3c;
    ev(23);
    rc(8'h0c, 8'h5a);
    wr(8'h04, 8'hc3);
    chk("jump", 8'hc3, pjl);
    chk("dummy", 8'h01, {7'h0, dc});
    wr(8'h08, 8'h3c);
    chk("table_pointer", 8'h3c, tp);
    wr(8'h1c, 8'hff);
    rc(8'h1c, 8'h17);
    chk("quick", 8'h01, {7'h0, qs});
    wr(8'h14, 8'h01);
    ev(25);
    rc(8'h14, 8'h00);
    ev(24);
    rc(8'h14, 8'h01);
    // rtc must stay off while fs is not the rtc oscillator
    wr(8'h20, 8'h3f);
    pins_in.wdt_en <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("seg", 8'h0f, {4'h0, seg});
    chk("lcd", 8'h01, {7'h0, lcd});
    chk("rtc", 8'h00, {7'h0, rtc});
    pins_in.fs_src <= 2'h2;
    wr(8'h20, 8'h00);
    repeat (8) @(posedge aclk);
    chk("rtc", 8'h01, {7'h0, rtc});
    pins_in.wdt_en <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("rtc", 8'h00, {7'h0, rtc});
    // port c latch against pin, then the open-drain enables of a and d
    pins_in.pc <= 1'b1;
    pins_in.pb <= 8'h81;
    wr(8'h40, 8'h00);
    wr(8'h44, 8'h00);
    rc(8'h40, 8'h00);
    chk("pc_oe", 8'h01, {7'h0, pc_oe});
    chk("pc_out", 8'h00, {7'h0, pc_out});
    wr(8'h44, 8'h01);
    rc(8'h40, 8'h01);
    wr(8'h38, 8'h0f);
    chk("pa_oe", 8'hf0, pa_oe);
    wr(8'h48, 8'h0a);
    chk("pd_oe", 8'h05, {4'h0, pd_oe});
    wr(8'h3c, 8'h00);
    rc(8'h3c, 8'h81);
    // preload both timers just short of overflow, run, then stop them
    wr(8'h24, 8'hfe);
    wr(8'h2c, 8'hff);
    wr(8'h30, 8'hfe);
    rc(8'h24, 8'hfe);
    rc(8'h2c, 8'hff);
    rc(8'h30, 8'hfe);
    wr(8'h28, 8'h10);
    wr(8'h34, 8'h10);
    wr(8'h28, 8'h00);
    wr(8'h34, 8'h00);
    rc(8'h18, 8'h06);
    wr(8'h14, 8'h05);
    chk("irq", 8'h01, {7'h0, irq});
    ev(25);
    @(posedge aclk);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h18, 8'h00);
    // smallest divider: the request waits for the 256th fs rise
    wr(8'h1c, 8'h10);
    wr(8'h20, 8'h20);
    repeat (255) tick();
    rc(8'h18, 8'h00);
    tick();
    rc(8'h18, 8'h01);
    wr(8'h4c, 8'h11, 2'b11);
    rc(8'h4c, 8'h00, 2'b11);
    summarize();
  end
endmodule : mcsr_top_tb_top
